// *** tbp_prescaler.sv ***
`timescale 1ns/1ns
module tbp_prescaler
   import tbp_pkg::*;
#(
   parameter int NT = TBP_NUM_TIMERS
)(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [1:0] BLOCK_PRESCALE_SEL,
   input wire logic [3*NT-1:0] TIMER_INPUT_PRESCALE_SEL,
   input wire logic [2*NT-1:0] TIMER_MODE,
   input wire logic [NT-1:0] TIMER_COUNT_INPUT,
   input wire logic [NT-1:0] TIMER_GATE_INPUT,
   input wire logic [NT-1:0] TIMER_DIR_INPUT,
   output logic BASIC_CLK_EN,
   output logic [NT-1:0] COUNT_EN,
   output logic [NT-1:0] COUNT_RISE,
   output logic [NT-1:0] COUNT_FALL,
   output logic [NT-1:0] GATE_LEVEL,
   output logic [NT-1:0] DIR_LEVEL,
   output logic [NT-1:0] DIR_EDGE
);
   localparam int NI = NT * TBP_INPUTS_PER_TIMER;

   function automatic logic [4:0] block_term(input logic [1:0] sel);
      unique case (sel)
         TBP_BPS_DIV4: block_term = TBP_BLOCK_TERM_4; // RULE_01
         TBP_BPS_DIV8: block_term = TBP_BLOCK_TERM_8;
         TBP_BPS_DIV16: block_term = TBP_BLOCK_TERM_16;
         TBP_BPS_DIV32: block_term = TBP_BLOCK_TERM_32;
      endcase
   endfunction : block_term

   logic [TBP_BLOCK_DIV_W-1:0] bdiv_q;
   logic basic_en_q;
   logic [1:0] bps_q;
   logic [TBP_TIMER_DIV_W-1:0] tdiv_q;
   logic [NT-1:0] count_en_q;
   logic [NT-1:0] rise_q;
   logic [NT-1:0] fall_q;
   logic [NT-1:0] gate_q;
   logic [NT-1:0] dir_q;
   logic [NT-1:0] dir_edge_q;

   tbp_samp_if #(.N(NI)) sif ();

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         bps_q <= TBP_BPS_RESET;
      else
         bps_q <= BLOCK_PRESCALE_SEL;
   end

   // block prescaler as a one-cycle enable
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         bdiv_q <= '0;
         basic_en_q <= 1'b0;
      end
      else if (bdiv_q >= block_term(bps_q))
      begin
         bdiv_q <= '0;
         basic_en_q <= 1'b1; // RULE_01 RULE_10
      end
      else
      begin
         bdiv_q <= bdiv_q + 5'h01;
         basic_en_q <= 1'b0;
      end
   end

   // shared basic-clock count; timer n fires when low sel bits all set
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         tdiv_q <= '0;
      else if (basic_en_q)
         tdiv_q <= tdiv_q + 7'h01; // RULE_02
   end

   assign sif.basic_en = basic_en_q;
   assign sif.pins = {TIMER_DIR_INPUT, TIMER_GATE_INPUT, TIMER_COUNT_INPUT};

   tbp_input_sampler #(.N(NI)) u_sampler (
      .clk(CLK),
      .resetn(RESETN),
      .sif(sif)
   );

   genvar t;
   generate
      for (t = 0; t < NT; t++)
      begin : g_timer
         logic [2:0] tsel;
         logic [1:0] tmode;
         logic [7:0] ext;
         logic tick;
         assign tsel = TIMER_INPUT_PRESCALE_SEL[3*t +: 3];
         assign tmode = TIMER_MODE[2*t +: 2];
         assign ext = {1'b1, tdiv_q};
         // tick after 2**tsel basic periods; overall factor block x timer
         assign tick = basic_en_q & (&(ext | ~((8'h01 << tsel) - 8'h01))); // RULE_02 RULE_03

         always_ff @(posedge CLK or negedge RESETN)
         begin
            if (!RESETN)
               count_en_q[t] <= 1'b0;
            else if (tmode == 2'(TBP_MODE_COUNTER))
               count_en_q[t] <= sif.rise[t] | sif.fall[t]; // RULE_04 RULE_10
            else if (tmode == 2'(TBP_MODE_GATED))
               count_en_q[t] <= tick & sif.level[NT*TBP_IN_GATE + t]; // RULE_09
            else if (tmode == 2'(TBP_MODE_TIMER))
               count_en_q[t] <= tick; // RULE_02
            else
               count_en_q[t] <= 1'b0;
         end

         always_ff @(posedge CLK or negedge RESETN)
         begin
            if (!RESETN)
            begin
               rise_q[t] <= 1'b0;
               fall_q[t] <= 1'b0;
               gate_q[t] <= 1'b0;
               dir_q[t] <= 1'b0;
               dir_edge_q[t] <= 1'b0;
            end
            else
            begin
               rise_q[t] <= sif.rise[NT*TBP_IN_COUNT + t];
               fall_q[t] <= sif.fall[NT*TBP_IN_COUNT + t];
               gate_q[t] <= sif.level[NT*TBP_IN_GATE + t];
               dir_q[t] <= sif.level[NT*TBP_IN_DIR + t]; // RULE_09
               dir_edge_q[t] <= sif.rise[NT*TBP_IN_DIR + t] | sif.fall[NT*TBP_IN_DIR + t];
            end
         end
      end
   endgenerate

   assign BASIC_CLK_EN = basic_en_q;
   assign COUNT_EN = count_en_q;
   assign COUNT_RISE = rise_q;
   assign COUNT_FALL = fall_q;
   assign GATE_LEVEL = gate_q;
   assign DIR_LEVEL = dir_q;
   assign DIR_EDGE = dir_edge_q;
endmodule : tbp_prescaler

// *** tbp_pkg.sv ***
// Summary of operation
// RULE_01: basic clock divides system clock by 4, 8, 16, 32 for select 01, 00, 11, 10.
// RULE_02: in timer modes each timer divides basic clock by two to its select.
// RULE_03: overall divider is block factor times timer factor, 4 up to 4096.
// RULE_04: counter mode counts on detected transitions of the timer input pins.
// RULE_05: every external input is sampled once per basic clock period.
// RULE_06: a transition is two consecutive basic clock samples with differing levels.
// RULE_07: source holds each input level at least one full basic clock period.
// RULE_08: input frequency stays at or below half the basic clock.
// RULE_09: sampling and hold limits apply to count, gate and direction inputs alike.
// RULE_10: basic and count clocks are single-cycle enables on the system clock.
package tbp_pkg;
   localparam int TBP_NUM_TIMERS = 3;
   localparam int TBP_INPUTS_PER_TIMER = 3;
   localparam logic [1:0] TBP_BPS_DIV4 = 2'h1;
   localparam logic [1:0] TBP_BPS_DIV8 = 2'h0;
   localparam logic [1:0] TBP_BPS_DIV16 = 2'h3;
   localparam logic [1:0] TBP_BPS_DIV32 = 2'h2;
   localparam logic [1:0] TBP_BPS_RESET = TBP_BPS_DIV8;
   localparam int TBP_BLOCK_DIV_W = 5;
   localparam int TBP_TIMER_DIV_W = 7;
   localparam logic [4:0] TBP_BLOCK_TERM_4 = 5'h03;
   localparam logic [4:0] TBP_BLOCK_TERM_8 = 5'h07;
   localparam logic [4:0] TBP_BLOCK_TERM_16 = 5'h0f;
   localparam logic [4:0] TBP_BLOCK_TERM_32 = 5'h1f;
   typedef enum logic [1:0] {TBP_MODE_TIMER, TBP_MODE_GATED, TBP_MODE_COUNTER} tbp_mode_t;
   localparam int TBP_IN_COUNT = 0;
   localparam int TBP_IN_GATE = 1;
   localparam int TBP_IN_DIR = 2;
endpackage : tbp_pkg

// *** tbp_samp_if.sv ***
`timescale 1ns/1ns
interface tbp_samp_if #(parameter int N = 9);
   logic basic_en;
   logic [N-1:0] pins;
   logic [N-1:0] level;
   logic [N-1:0] rise;
   logic [N-1:0] fall;
   modport sampler (input basic_en, input pins, output level, output rise, output fall);
   modport user (output basic_en, output pins, input level, input rise, input fall);
endinterface : tbp_samp_if

// *** tbp_input_sampler.sv ***
`timescale 1ns/1ns
module tbp_input_sampler
   import tbp_pkg::*;
#(
   parameter int N = 9
)(
   input wire logic clk,
   input wire logic resetn,
   tbp_samp_if.sampler sif
);
   logic [N-1:0] meta_q;
   logic [N-1:0] sync_q;
   logic [N-1:0] smp_q;
   logic [N-1:0] rise_q;
   logic [N-1:0] fall_q;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= sif.pins;
         sync_q <= meta_q;
      end
   end

   // one sample per basic clock period
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         smp_q <= '0;
      else if (sif.basic_en)
         smp_q <= sync_q; // RULE_05 RULE_09
   end

   // edge pulse for one system cycle after a differing sample pair
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rise_q <= '0;
         fall_q <= '0;
      end
      else
      begin
         rise_q <= sif.basic_en ? (sync_q & ~smp_q) : '0; // RULE_06
         fall_q <= sif.basic_en ? (~sync_q & smp_q) : '0; // RULE_06
      end
   end

   assign sif.level = smp_q;
   assign sif.rise = rise_q;
   assign sif.fall = fall_q;
endmodule : tbp_input_sampler

// *** tbp_chk.sv ***
`timescale 1ns/1ns
module tbp_chk
   import tbp_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [1:0] BLOCK_PRESCALE_SEL,
   input wire logic [5:0] TIMER_MODE,
   input wire logic BASIC_CLK_EN,
   input wire logic [2:0] COUNT_EN,
   input wire logic [2:0] COUNT_RISE,
   input wire logic [2:0] COUNT_FALL,
   input wire logic [2:0] GATE_LEVEL,
   input wire logic [2:0] DIR_LEVEL,
   input wire logic [2:0] DIR_EDGE
);
   logic [5:0] cnt_q;
   wire logic [5:0] f = 6'h04 << (BLOCK_PRESCALE_SEL ^ 2'h1);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   // cycles since the last basic pulse
   always_ff @(posedge CLK or negedge RESETN)
      if (!RESETN)
         cnt_q <= 6'h00;
      else
         cnt_q <= BASIC_CLK_EN ? 6'h01 : cnt_q + 6'h01;
   sequence s_quiet;
      !BASIC_CLK_EN [*3];
   endsequence
   a_basic_period: assert property (BASIC_CLK_EN |-> cnt_q == f)
      else $error("basic pulse spacing wrong");
   a_basic_gap: assert property (cnt_q <= f)
      else $error("basic pulse late");
   a_basic_single: assert property (BASIC_CLK_EN |=> s_quiet)
      else $error("basic pulse too long");
   a_count_single: assert property (COUNT_EN[0] |=> !COUNT_EN[0])
      else $error("count pulse too long");
   a_count_align: assert property (|COUNT_EN |-> $past(BASIC_CLK_EN) || $past(BASIC_CLK_EN, 2))
      else $error("count pulse not after basic pulse");
   a_counter_src: assert property ($past(TIMER_MODE[1:0]) == 2'h2 &&
      $past(TIMER_MODE[1:0], 2) == 2'h2 |-> COUNT_EN[0] == (COUNT_RISE[0] | COUNT_FALL[0]))
      else $error("counter mode count not from pin edge");
   a_level_sample: assert property (!$stable(GATE_LEVEL) |-> $past(BASIC_CLK_EN, 2))
      else $error("gate level changed off sample");
   a_dir_edge: assert property (DIR_EDGE == (DIR_LEVEL ^ $past(DIR_LEVEL)))
      else $error("direction edge disagrees with samples");
endmodule : tbp_chk
bind tbp_prescaler tbp_chk u_chk (.CLK(CLK), .RESETN(RESETN),
   .BLOCK_PRESCALE_SEL(BLOCK_PRESCALE_SEL), .TIMER_MODE(TIMER_MODE),
   .BASIC_CLK_EN(BASIC_CLK_EN), .COUNT_EN(COUNT_EN), .COUNT_RISE(COUNT_RISE),
   .COUNT_FALL(COUNT_FALL), .GATE_LEVEL(GATE_LEVEL), .DIR_LEVEL(DIR_LEVEL),
   .DIR_EDGE(DIR_EDGE));

// *** tbp_src.sv ***
`timescale 1ns/1ns
module tbp_src (
   input wire logic clk,
   input wire logic [7:0] hold,
   input wire logic [8:0] pat,
   output logic [8:0] pins
);
   int n = 0;
   initial pins = 9'h000;
   // levels held two basic periods, so no edge is lost
   always @(posedge clk)
   begin
      n <= (n + 1 >= hold) ? 0 : n + 1;
      if (n + 1 >= hold)
         pins <= pins ^ pat;
   end
endmodule : tbp_src

// *** tbp_prescaler_test.sv ***
`timescale 1ns/1ns
module tbp_prescaler_test;
   import tbp_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [1:0] bps = 2'h0;
   logic [8:0] tsel = 9'h000;
   logic [5:0] mode = 6'h00;
   logic [8:0] pat = 9'h000;
   logic [7:0] hold = 8'h10;
   logic [8:0] pins;
   logic basic;
   logic [2:0] cen, gate, dir;
   logic [2:0] rise, fall, dedge;
   logic [31:0] seed = 32'h00a6e232;
   int err_count = 0;
   int cmp_count = 0;
   tbp_prescaler dut (.CLK(clk), .RESETN(resetn), .BLOCK_PRESCALE_SEL(bps),
      .TIMER_INPUT_PRESCALE_SEL(tsel), .TIMER_MODE(mode), .TIMER_COUNT_INPUT(pins[2:0]),
      .TIMER_GATE_INPUT(pins[5:3]), .TIMER_DIR_INPUT(pins[8:6]), .BASIC_CLK_EN(basic),
      .COUNT_EN(cen), .COUNT_RISE(rise), .COUNT_FALL(fall), .GATE_LEVEL(gate),
      .DIR_LEVEL(dir), .DIR_EDGE(dedge));
   tbp_src src (.clk(clk), .hold(hold), .pat(pat), .pins(pins));
   initial forever #20 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic int bfac(input logic [1:0] s);
      return 4 << (s ^ 2'h1);
   endfunction : bfac
   task automatic report_and_stop;
      if (err_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic check(input int got, input int want);
      cmp_count++;
      if (got != want)
      begin
         err_count++;
         $display("mismatch at %0t: got %0d want %0d", $time, got, want);
      end
   endtask : check
   // cycles between two pulses of basic (k < 0), a count enable (k < 3),
   // else rise (3), fall (4) or direction edge (5) of timer 0
   task automatic period(input int k, output int p);
      int i;
      logic hit;
      p = -1;
      for (i = 0; i < 9000; i++)
      begin
         @(posedge clk);
         #1;
         hit = (k < 0) ? basic : (k < 3) ? cen[k] : (k == 3) ? rise[0] :
            (k == 4) ? fall[0] : dedge[0];
         if (p >= 0)
            p++;
         if (hit === 1'b1 && p > 0)
            break;
         if (hit === 1'b1)
            p = 0;
      end
      if (i == 9000)
      begin
         err_count++;
         $display("mismatch at %0t: no pulse within limit", $time);
         report_and_stop();
      end
   endtask : period
   // count enable pulses of timer 0 seen in len cycles
   task automatic pulses(input int len, output int n);
      int i;
      n = 0;
      for (i = 0; i < len; i++)
      begin
         @(posedge clk);
         #1;
         if (cen[0] === 1'b1)
            n++;
      end
   endtask : pulses
   initial
   begin
      int p;
      int n;
      for (int b = 0; b < 4; b++)
      begin
         @(posedge clk);
         seed = lfsr(seed);
         resetn <= 1'b0;
         bps <= b[1:0];
         tsel <= (b == 0) ? 9'h000 : (b == 3) ? 9'h1ff : seed[8:0];
         mode <= 6'h00;
         pat <= 9'h000;
         hold <= 8'(2 * bfac(b[1:0]));
         repeat (3) @(posedge clk);
         resetn <= 1'b1;
         period(-1, p);
         check(p, bfac(b[1:0]));
         for (int s = 0; s < 3; s++)
         begin
            period(s, p);
            check(p, bfac(b[1:0]) << tsel[3*s+:3]);
         end
         @(posedge clk);
         mode <= 6'h2a;
         pat <= seed[17:9] | 9'h041;
         period(0, p);
         period(0, p);
         check(p, int'(hold));
         period(3, p);
         check(p, 2 * int'(hold));
         period(4, p);
         check(p, 2 * int'(hold));
         period(5, p);
         check(p, int'(hold));
         @(posedge clk);
         pat <= 9'h000;
         repeat (4 * hold) @(posedge clk);
         #1;
         check(int'(gate === pins[5:3] && dir === pins[8:6]), 1);
         @(posedge clk);
         mode <= 6'h15;
         pulses(2 * (bfac(b[1:0]) << tsel[2:0]), n);
         check(n, (pins[3] === 1'b1) ? 2 : 0);
         @(posedge clk);
         mode <= 6'h3f;
         pulses(4 * hold, n);
         check(n, 0);
      end
      report_and_stop();
   end
endmodule : tbp_prescaler_test
